// *** logic/nps_top.sv ***
// poll demand registers and event status register of the host interface
`timescale 1ns/1ps
`include "nps_defs.svh"

// Operation
// - tx poll write starts tx list fetch unless bus halted
// - rx poll write starts rx list fetch unless bus halted
// - wake-up bit 28 only while wake enabled
// - bit 27 on every fast link change
// - bus error cause code in bits 25:23
// - tx process state shown in bits 22:20
// - rx process state tracked in bits 19:17
// - rx state codes as defined by engine
// - bit 16 is OR of 0,2,6,28
// - bit 15 is OR of abnormal bits
// - early receive event sets bit 14
// - bus error sets bit 13, halts bus
// - slow link fail qualified by port settings
// - timer expiry sets bit 11
// - early tx sets bit 10, tx done clears
// - receive watchdog expiry sets bit 9
// - rx buffer unavailable sets bit 7
// - tx done bit 0, rx done bit 6
// - tx underflow sets bit 5
// - link pass or test disable sets bit 4
// - negotiation done sets bit 4, fail clears
// - jabber aborts tx, sets bit 3, descriptor
// - tx buffer unavailable bit 2, tx stopped bit 1
module nps_top
	import nps_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_tx_done,
	input wire logic i_rx_done,
	input wire logic i_tx_buf_unavail,
	input wire logic i_tx_jabber,
	input wire logic i_tx_underflow,
	input wire logic i_rx_buf_unavail,
	input wire logic i_rx_watchdog,
	input wire logic i_tx_fifo_loaded,
	input wire logic i_gp_timer_expired,
	input wire logic i_slow_link_fail,
	input wire logic i_slow_link_pass,
	input wire logic i_early_rx,
	input wire logic i_wakeup_event,
	input wire logic i_bus_error,
	input wire logic [2:0] i_bus_error_code,
	input wire logic i_fast_link_up,
	input wire logic i_autoneg_en,
	input wire logic [2:0] i_neg_state,
	input wire logic i_link_test_en,
	input wire logic i_port_select,
	input wire logic i_link_port_enable,
	input wire logic i_phy_reset_hold,
	input wire logic i_wake_enable,
	input wire logic [2:0] i_tx_state,
	input wire logic [2:0] i_rx_state,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic o_tx_poll,
	output logic o_rx_poll,
	output logic o_bus_halt,
	output logic o_tx_abort,
	output logic o_tx_desc_jabber
);
	nps_state_t st_r;
	nps_state_t st_nxt;
	logic [31:0] set_v;
	logic [31:0] clr_v;
	logic [31:0] auto_clr;
	logic wr_status;
	logic slow_port;
	logic neg_done;

	function automatic logic [31:0] status_word(input nps_state_t s);
		logic [31:0] w;
		w = s.sticky & `NPS_EVENT_MASK;
		w[`NPS_B_NORMAL_SUM] = |(w & `NPS_NORMAL_MASK);
		w[`NPS_B_ABNORMAL_SUM] = |(w & `NPS_ABNORMAL_MASK);
		w[`NPS_F_RX_STATE_LO +: 3] = s.rx_state;
		w[`NPS_F_TX_STATE_LO +: 3] = s.tx_state;
		w[`NPS_F_BUS_CODE_LO +: 3] = s.bus_code;
		return w;
	endfunction

	always_comb begin
		st_nxt = st_r;
		set_v = `NPS_ZERO32;
		auto_clr = `NPS_ZERO32;
		slow_port = !i_port_select;
		neg_done = (i_neg_state == `NPS_NEG_DONE);
		wr_status = i_reg_wr && (i_reg_addr == `NPS_OFF_STATUS);
		clr_v = wr_status ? (i_reg_wdata & `NPS_EVENT_MASK) : `NPS_ZERO32;

		set_v[`NPS_B_TX_DONE] = i_tx_done;
		set_v[`NPS_B_RX_DONE] = i_rx_done;
		set_v[`NPS_B_TX_BUF_UNAVAIL] = i_tx_buf_unavail;
		set_v[`NPS_B_TX_STOPPED] = (i_tx_state == `NPS_TX_STOPPED)
			&& (st_r.tx_state != `NPS_TX_STOPPED);
		set_v[`NPS_B_TX_JABBER] = i_tx_jabber;
		set_v[`NPS_B_TX_UNDERFLOW] = i_tx_underflow;
		set_v[`NPS_B_RX_BUF_UNAVAIL] = i_rx_buf_unavail;
		set_v[`NPS_B_RX_WATCHDOG] = i_rx_watchdog;
		set_v[`NPS_B_EARLY_TX] = i_tx_fifo_loaded;
		set_v[`NPS_B_GP_TIMER] = i_gp_timer_expired;
		set_v[`NPS_B_SLOW_LINK_FAIL] = i_slow_link_fail && slow_port
			&& i_link_port_enable && !i_phy_reset_hold;
		set_v[`NPS_B_FATAL_BUS] = i_bus_error && !st_r.bus_halt;
		set_v[`NPS_B_EARLY_RX] = i_early_rx;
		set_v[`NPS_B_FAST_LINK_CHG] =
			(i_fast_link_up != st_r.fast_link_q);
		set_v[`NPS_B_WAKEUP] = i_wakeup_event && i_wake_enable;
		if (slow_port) begin
			if (i_autoneg_en) begin
				set_v[`NPS_B_LINK_PASS] = neg_done && !st_r.neg_done_q;
			end else begin
				set_v[`NPS_B_LINK_PASS] = i_slow_link_pass
					|| (st_r.link_test_q && !i_link_test_en);
			end
		end
		// link fail clears link pass, tx done clears early tx
		auto_clr[`NPS_B_LINK_PASS] = set_v[`NPS_B_SLOW_LINK_FAIL];
		auto_clr[`NPS_B_EARLY_TX] = set_v[`NPS_B_TX_DONE];
		set_v = set_v & ~auto_clr;
		// set wins over a software clear in the same cycle
		st_nxt.sticky = ((st_r.sticky & ~clr_v & ~auto_clr) | set_v)
			& `NPS_EVENT_MASK;

		if (set_v[`NPS_B_FATAL_BUS]) begin
			st_nxt.bus_code = i_bus_error_code;
			st_nxt.bus_halt = 1'b1;
		end
		st_nxt.tx_state = i_tx_state;
		st_nxt.rx_state = i_rx_state;
		st_nxt.fast_link_q = i_fast_link_up;
		st_nxt.neg_done_q = neg_done;
		st_nxt.link_test_q = i_link_test_en;
		st_nxt.tx_abort = i_tx_jabber;
		st_nxt.tx_desc_jabber = i_tx_jabber;

		// poll writes ignored once bus access is halted
		st_nxt.tx_poll = i_reg_wr && (i_reg_addr == `NPS_OFF_TX_POLL)
			&& !st_r.bus_halt;
		st_nxt.rx_poll = i_reg_wr && (i_reg_addr == `NPS_OFF_RX_POLL)
			&& !st_r.bus_halt;

		st_nxt.rvalid = i_reg_rd;
		st_nxt.rdata = `NPS_ZERO32;
		if (i_reg_rd && (i_reg_addr == `NPS_OFF_STATUS)) begin
			st_nxt.rdata = status_word(st_r);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_reg_rdata = st_r.rdata;
	assign o_reg_rvalid = st_r.rvalid;
	assign o_tx_poll = st_r.tx_poll;
	assign o_rx_poll = st_r.rx_poll;
	assign o_bus_halt = st_r.bus_halt;
	assign o_tx_abort = st_r.tx_abort;
	assign o_tx_desc_jabber = st_r.tx_desc_jabber;

	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	a_tx_poll_pulse: assert property (
		i_reg_wr && i_reg_addr == `NPS_OFF_TX_POLL && !o_bus_halt
		|=> o_tx_poll)
		else $error("tx poll write gave no poll pulse");
	a_rx_poll_pulse: assert property (
		i_reg_wr && i_reg_addr == `NPS_OFF_RX_POLL && !o_bus_halt
		|=> o_rx_poll)
		else $error("rx poll write gave no poll pulse");
	a_wake_gated: assert property (
		!$past(st_r.sticky[`NPS_B_WAKEUP]) && st_r.sticky[`NPS_B_WAKEUP]
		|-> $past(i_wake_enable))
		else $error("wake-up set while disabled");
	a_link_change: assert property (
		i_fast_link_up != $past(i_fast_link_up)
		|=> st_r.sticky[`NPS_B_FAST_LINK_CHG])
		else $error("fast link change not flagged");
	a_bus_code_hold: assert property (
		o_bus_halt |=> $stable(st_r.bus_code))
		else $error("bus error code changed after halt");
	a_tx_state_track: assert property (
		##1 st_r.tx_state == $past(i_tx_state))
		else $error("tx state not tracked");
	a_rx_state_track: assert property (
		##1 st_r.rx_state == $past(i_rx_state))
		else $error("rx state not tracked");
	a_normal_sum: assert property (
		o_reg_rvalid && $past(i_reg_addr) == `NPS_OFF_STATUS
		|-> o_reg_rdata[`NPS_B_NORMAL_SUM]
		== |(o_reg_rdata & `NPS_NORMAL_MASK))
		else $error("normal summary mismatch");
	a_abnormal_sum: assert property (
		o_reg_rvalid && $past(i_reg_addr) == `NPS_OFF_STATUS
		|-> o_reg_rdata[`NPS_B_ABNORMAL_SUM]
		== |(o_reg_rdata & `NPS_ABNORMAL_MASK))
		else $error("abnormal summary mismatch");
	a_halt_sticky: assert property (
		i_bus_error |=> o_bus_halt ##1 o_bus_halt)
		else $error("bus halt not held");
	a_halt_no_poll: assert property (
		o_bus_halt |=> !o_tx_poll && !o_rx_poll)
		else $error("poll issued after bus halt");
	a_fail_qual: assert property (
		i_slow_link_fail && (i_port_select || i_phy_reset_hold
		|| !i_link_port_enable) && !st_r.sticky[`NPS_B_SLOW_LINK_FAIL]
		|=> !st_r.sticky[`NPS_B_SLOW_LINK_FAIL])
		else $error("link fail set while not qualified");
	a_early_tx_clr: assert property (
		i_tx_done |=> !st_r.sticky[`NPS_B_EARLY_TX])
		else $error("tx done did not clear early tx");
	a_fail_clr_pass: assert property (
		set_v[`NPS_B_SLOW_LINK_FAIL] |=> !st_r.sticky[`NPS_B_LINK_PASS])
		else $error("link fail did not clear link pass");
	a_jabber_abort: assert property (
		i_tx_jabber |=> o_tx_abort && o_tx_desc_jabber
		&& st_r.sticky[`NPS_B_TX_JABBER])
		else $error("jabber handling incomplete");
	a_set_wins: assert property (
		i_rx_done && wr_status && i_reg_wdata[`NPS_B_RX_DONE]
		|=> st_r.sticky[`NPS_B_RX_DONE])
		else $error("event lost to clear");
	a_w1c_clear: assert property (
		wr_status && i_reg_wdata[`NPS_B_TX_UNDERFLOW] && !i_tx_underflow
		|=> !st_r.sticky[`NPS_B_TX_UNDERFLOW])
		else $error("write one did not clear");

	a_tx_done_set: assert property (
		i_tx_done |=> st_r.sticky[`NPS_B_TX_DONE])
		else $error("tx done not flagged");

	a_rx_done_set: assert property (
		i_rx_done |=> st_r.sticky[`NPS_B_RX_DONE])
		else $error("rx done not flagged");

	a_tx_unavail_set: assert property (
		i_tx_buf_unavail |=> st_r.sticky[`NPS_B_TX_BUF_UNAVAIL])
		else $error("tx buffer unavailable not flagged");

	a_tx_stop_set: assert property (
		i_tx_state == `NPS_TX_STOPPED && st_r.tx_state != `NPS_TX_STOPPED
		|=> st_r.sticky[`NPS_B_TX_STOPPED])
		else $error("tx stop not flagged");

	a_underflow_set: assert property (
		i_tx_underflow |=> st_r.sticky[`NPS_B_TX_UNDERFLOW])
		else $error("tx underflow not flagged");

	a_rx_unavail_set: assert property (
		i_rx_buf_unavail |=> st_r.sticky[`NPS_B_RX_BUF_UNAVAIL])
		else $error("rx buffer unavailable not flagged");

	a_watchdog_set: assert property (
		i_rx_watchdog |=> st_r.sticky[`NPS_B_RX_WATCHDOG])
		else $error("rx watchdog not flagged");

	a_early_tx_set: assert property (
		i_tx_fifo_loaded && !i_tx_done |=> st_r.sticky[`NPS_B_EARLY_TX])
		else $error("early tx not flagged");

	a_timer_set: assert property (
		i_gp_timer_expired |=> st_r.sticky[`NPS_B_GP_TIMER])
		else $error("timer expiry not flagged");

	a_early_rx_set: assert property (
		i_early_rx |=> st_r.sticky[`NPS_B_EARLY_RX])
		else $error("early rx not flagged");

	a_wake_set: assert property (
		i_wakeup_event && i_wake_enable |=> st_r.sticky[`NPS_B_WAKEUP])
		else $error("enabled wake-up not flagged");

	a_fail_set: assert property (
		i_slow_link_fail && !i_port_select && i_link_port_enable
		&& !i_phy_reset_hold |=> st_r.sticky[`NPS_B_SLOW_LINK_FAIL])
		else $error("qualified link fail not flagged");

	a_bus_err_set: assert property (
		i_bus_error && !o_bus_halt
		|=> st_r.sticky[`NPS_B_FATAL_BUS] && o_bus_halt)
		else $error("bus error not flagged");

	a_bus_code_take: assert property (
		i_bus_error && !o_bus_halt
		|=> st_r.bus_code == $past(i_bus_error_code))
		else $error("bus error code not captured");

	a_halt_hold: assert property (
		o_bus_halt |=> o_bus_halt)
		else $error("bus halt dropped");

	a_neg_pass: assert property (
		!i_port_select && i_autoneg_en && i_neg_state == `NPS_NEG_DONE
		&& !st_r.neg_done_q && !set_v[`NPS_B_SLOW_LINK_FAIL]
		|=> st_r.sticky[`NPS_B_LINK_PASS])
		else $error("negotiation done not flagged");

	a_test_off_pass: assert property (
		!i_port_select && !i_autoneg_en && st_r.link_test_q
		&& !i_link_test_en && !set_v[`NPS_B_SLOW_LINK_FAIL]
		|=> st_r.sticky[`NPS_B_LINK_PASS])
		else $error("link test disable not flagged");

	a_link_pass_set: assert property (
		!i_port_select && !i_autoneg_en && i_slow_link_pass
		&& !set_v[`NPS_B_SLOW_LINK_FAIL]
		|=> st_r.sticky[`NPS_B_LINK_PASS])
		else $error("link pass not flagged");

	a_pass_port_gate: assert property (
		i_port_select && !st_r.sticky[`NPS_B_LINK_PASS]
		|=> !st_r.sticky[`NPS_B_LINK_PASS])
		else $error("link pass set on fast port");

	a_rvalid_track: assert property (
		o_reg_rvalid == $past(i_reg_rd))
		else $error("read valid not one cycle after read");

	a_rdata_idle: assert property (
		!o_reg_rvalid |-> o_reg_rdata == `NPS_ZERO32)
		else $error("read data not zero while idle");

	a_bit8_zero: assert property (
		o_reg_rvalid |-> !o_reg_rdata[`NPS_B_RX_POLL_CMD])
		else $error("bit 8 read nonzero");

	a_tx_poll_src: assert property (
		o_tx_poll |-> $past(i_reg_wr)
		&& $past(i_reg_addr) == `NPS_OFF_TX_POLL)
		else $error("tx poll pulse without write");

	a_rx_poll_src: assert property (
		o_rx_poll |-> $past(i_reg_wr)
		&& $past(i_reg_addr) == `NPS_OFF_RX_POLL)
		else $error("rx poll pulse without write");

	a_sticky_hold: assert property (
		st_r.sticky[`NPS_B_TX_DONE]
		&& !(wr_status && i_reg_wdata[`NPS_B_TX_DONE])
		|=> st_r.sticky[`NPS_B_TX_DONE])
		else $error("event bit lost without clear");


	c_tx_poll: cover property (i_reg_wr ##1 o_tx_poll);
	c_bus_error: cover property (i_bus_error ##1 o_bus_halt);
	c_clear_race: cover property (i_tx_done && wr_status);
	c_neg_done: cover property (set_v[`NPS_B_LINK_PASS] && i_autoneg_en);
	c_fail_gated: cover property (i_slow_link_fail && i_port_select);
endmodule

// *** logic/nps_defs.svh ***
// register offsets, field positions, masks and state codes of the poll and status logic
`ifndef NPS_DEFS_SVH
`define NPS_DEFS_SVH

`define NPS_ADDR_W 8
`define NPS_OFF_TX_POLL 8'h08
`define NPS_OFF_RX_POLL 8'h10
`define NPS_OFF_STATUS 8'h28

`define NPS_B_TX_DONE 0
`define NPS_B_TX_STOPPED 1
`define NPS_B_TX_BUF_UNAVAIL 2
`define NPS_B_TX_JABBER 3
`define NPS_B_LINK_PASS 4
`define NPS_B_TX_UNDERFLOW 5
`define NPS_B_RX_DONE 6
`define NPS_B_RX_BUF_UNAVAIL 7
`define NPS_B_RX_POLL_CMD 8
`define NPS_B_RX_WATCHDOG 9
`define NPS_B_EARLY_TX 10
`define NPS_B_GP_TIMER 11
`define NPS_B_SLOW_LINK_FAIL 12
`define NPS_B_FATAL_BUS 13
`define NPS_B_EARLY_RX 14
`define NPS_B_ABNORMAL_SUM 15
`define NPS_B_NORMAL_SUM 16
`define NPS_F_RX_STATE_LO 17
`define NPS_F_TX_STATE_LO 20
`define NPS_F_BUS_CODE_LO 23
`define NPS_B_FAST_LINK_CHG 27
`define NPS_B_WAKEUP 28

`define NPS_EVENT_MASK 32'h18007EFF
`define NPS_NORMAL_MASK 32'h10000045
`define NPS_ABNORMAL_MASK 32'h08002FAA
`define NPS_ZERO32 32'h00000000
`define NPS_ZERO3 3'h0
`define NPS_TX_STOPPED 3'h0
`define NPS_RX_STOPPED 3'h0
`define NPS_BUS_CODE_PARITY 3'h0
`define NPS_BUS_CODE_MASTER 3'h1
`define NPS_BUS_CODE_TARGET 3'h2
`define NPS_NEG_DONE 3'h5

`endif

// *** logic/nps_pkg.sv ***
// types of the poll and status logic
package nps_pkg;
	typedef enum logic [2:0] {
		NPS_TX_STOP,
		NPS_TX_FETCH,
		NPS_TX_WAIT_END,
		NPS_TX_FILL,
		NPS_TX_RSVD,
		NPS_TX_SETUP,
		NPS_TX_SUSPEND,
		NPS_TX_CLOSE
	} nps_tx_code_t;

	typedef struct packed {
		logic [31:0] sticky;
		logic [2:0] bus_code;
		logic [2:0] tx_state;
		logic [2:0] rx_state;
		logic [31:0] rdata;
		logic rvalid;
		logic tx_poll;
		logic rx_poll;
		logic bus_halt;
		logic tx_abort;
		logic tx_desc_jabber;
		logic fast_link_q;
		logic neg_done_q;
		logic link_test_q;
	} nps_state_t;
endpackage

// *** verification/nps_host_model.sv ***
// host side register access model for the poll and status logic
`timescale 1ns/1ps
module nps_host_model (
	input wire logic i_clk_sys,
	input wire logic [31:0] i_rdata,
	input wire logic i_rvalid,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [31:0] o_wdata
);
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 32'h00000000;
	end
	// one-cycle write strobe; a 1 clears a status event
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge i_clk_sys);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_clk_sys);
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask
	// data taken the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic v);
		@(negedge i_clk_sys);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk_sys);
		o_rd = 1'b0;
		o_addr = ~a;
		d = i_rdata;
		v = i_rvalid;
	endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench of the poll and status logic
`timescale 1ns/1ps
`include "nps_defs.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
	logic clk = 1'b0, srst = 1'b1, wake = 1'b1, be = 1'b0, fl = 1'b0;
	logic lte = 1'b1, v;
	logic [2:0] bcode = 3'h0, txs = 3'h0, rxs = 3'h0;
	logic [12:0] ev = 13'h0000;
	logic [7:0] a;
	logic wr, rd, rv, txp, rxp, halt, abt, dj;
	logic ps = 1'b0, an = 1'b0, phr = 1'b0, lpe = 1'b1;
	logic [2:0] ns = 3'h0;
	logic [31:0] wd, rdat, d, e;
	int err_total = 0, compares = 0, cyc = 0;
	int bpos[13] = '{0, 2, 3, 5, 6, 7, 9, 10, 11, 14, 28, 12, 4};
	nps_top i_nps_top (.i_clk_sys(clk), .i_srst(srst), .i_reg_addr(a),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .i_tx_done(ev[0]),
		.i_tx_buf_unavail(ev[1]), .i_tx_jabber(ev[2]),
		.i_tx_underflow(ev[3]), .i_rx_done(ev[4]), .i_rx_buf_unavail(ev[5]),
		.i_rx_watchdog(ev[6]), .i_tx_fifo_loaded(ev[7]),
		.i_gp_timer_expired(ev[8]), .i_early_rx(ev[9]),
		.i_wakeup_event(ev[10]), .i_slow_link_fail(ev[11]),
		.i_slow_link_pass(ev[12]), .i_bus_error(be), .i_bus_error_code(bcode),
		.i_fast_link_up(fl), .i_autoneg_en(an), .i_neg_state(ns),
		.i_link_test_en(lte), .i_port_select(ps), .i_link_port_enable(lpe),
		.i_phy_reset_hold(phr), .i_wake_enable(wake), .i_tx_state(txs),
		.i_rx_state(rxs), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
		.o_tx_poll(txp), .o_rx_poll(rxp), .o_bus_halt(halt),
		.o_tx_abort(abt), .o_tx_desc_jabber(dj));
	nps_host_model i_nps_host_model (.i_clk_sys(clk), .i_rdata(rdat),
		.i_rvalid(rv), .o_addr(a), .o_wr(wr), .o_rd(rd), .o_wdata(wd));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic rd_stat(input logic [31:0] exp);
		i_nps_host_model.rd(`NPS_OFF_STATUS, d, v);
		`CHK("rvalid", 1'b1, v)
		`CHK("status", exp, d)
	endtask
	function automatic logic [31:0] summ(input logic [31:0] x);
		summ = x | ((x & `NPS_NORMAL_MASK) != 0 ? 32'h00010000 : 32'h0);
		summ = summ | ((x & `NPS_ABNORMAL_MASK) != 0 ? 32'h00008000 : 32'h0);
	endfunction
	task automatic t_poll();
		i_nps_host_model.wr(`NPS_OFF_TX_POLL, 32'hFFFFFFFF);
		`CHK("tx poll", 2'b10, {txp, rxp})
		i_nps_host_model.wr(`NPS_OFF_RX_POLL, 32'h00000000);
		`CHK("rx poll", 2'b01, {txp, rxp})
	endtask
	task automatic t_events();
		for (int k = 0; k < 13; k++) begin
			@(negedge clk);
			ev[k] = 1'b1;
			@(negedge clk);
			`CHK("jabber out", {2{k == 2}}, {abt, dj})
			ev[k] = 1'b0;
			e = 32'h1 << bpos[k];
			rd_stat(summ(e));
			i_nps_host_model.wr(`NPS_OFF_STATUS, e);
			rd_stat(32'h0);
		end
	endtask
	task automatic t_link();
		an = 1'b1;
		ns = `NPS_NEG_DONE;
		@(negedge clk);
		rd_stat(32'h00000010);
		i_nps_host_model.wr(`NPS_OFF_STATUS, 32'h00000010);
		ps = 1'b1;
		ns = 3'h0;
		wake = 1'b0;
		ev[10] = 1'b1;
		ev[11] = 1'b1;
		@(negedge clk);
		ns = `NPS_NEG_DONE;
		@(negedge clk);
		ev[10] = 1'b0;
		ps = 1'b0;
		phr = 1'b1;
		@(negedge clk);
		phr = 1'b0;
		lpe = 1'b0;
		@(negedge clk);
		ev[11] = 1'b0;
		lpe = 1'b1;
		an = 1'b0;
		ns = 3'h0;
		wake = 1'b1;
		rd_stat(32'h0);
	endtask
	task automatic t_misc();
		ev[7] = 1'b1;
		@(negedge clk);
		ev[7] = 1'b0;
		ev[0] = 1'b1;
		@(negedge clk);
		ev[0] = 1'b0;
		txs = 3'h5;
		rxs = 3'h3;
		fl = 1'b1;
		lte = 1'b0;
		@(negedge clk);
		rd_stat(summ(32'h08560011));
		txs = 3'h0;
		ev[11] = 1'b1;
		@(negedge clk);
		ev[11] = 1'b0;
		rd_stat(summ(32'h08061003));
		i_nps_host_model.wr(`NPS_OFF_STATUS, 32'hFFFFFFFF);
		rxs = 3'h0;
		fl = 1'b0;
		be = 1'b1;
		bcode = `NPS_BUS_CODE_TARGET;
		@(negedge clk);
		be = 1'b0;
		rd_stat(summ(32'h09002000));
		`CHK("halt", 1'b1, halt)
		i_nps_host_model.wr(`NPS_OFF_TX_POLL, 32'h00000001);
		`CHK("poll halted", 1'b0, txp)
	endtask
	initial begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		rd_stat(32'h0);
		t_poll();
		t_events();
		t_link();
		t_misc();
		complete_run();
	end
endmodule
